// *** rtcp_port.sv ***
// Remote test control port: pin sampling, measurement sequencing and APB registers.
// Functional notes
// - All control lines are active low.
// - Lock input low locks front-panel keys.
// - Stop input aborts the running measurement.
// - Panel number is complement of select code.
// - Select set first, start low begins measuring.
// - Start recalls panel addressed by select code.
// - Item strobe pulses low per measurement item.
// - Pass output low on pass judgement.
// - Low-fail output low below lower limit.
// - High-fail output low above upper limit.
// - Remote connection shows indicator, forces key lock.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module rtcp_port
    import rtcp_pkg::*;
#(
    parameter int STROBE_CYCLES = rtcp_pkg::STROBE_CYC
)
(
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic                      panel_lock_n,
    input  wire logic                      start_n,
    input  wire logic                      stop_n,
    input  wire logic                      panel_sel_b0_n,
    input  wire logic                      panel_sel_b1_n,
    input  wire logic                      panel_sel_b2_n,
    input  wire logic                      panel_sel_b3_n,
    input  wire logic                      panel_sel_b4_n,
    output logic                           testing_n,
    output logic                           item_strobe_n,
    output logic                           pass_n,
    output logic                           lfail_n,
    output logic                           hfail_n,
    output logic                           keys_locked,
    output logic                           remote_icon,
    output logic                           recall_valid,
    output logic [rtcp_pkg::SEL_W-1:0]     recall_panel,
    output logic                           abort,
    output logic                           irq,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr
);
    import rtcp_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [7:0] pins_s;

    rtcp_sync
    #(
        .W    (8),
        .INIT (8'hFF)
    )
    u_sync
    (
        .clock    (clock),
        .reset    (reset),
        .async_in ({panel_sel_b4_n, panel_sel_b3_n, panel_sel_b2_n, panel_sel_b1_n,
                    panel_sel_b0_n, stop_n, start_n, panel_lock_n}),
        .sync_out (pins_s)
    );

    logic             lock_act;
    logic             start_act;
    logic             stop_act;
    logic [SEL_W-1:0] sel_code;
    logic [SEL_W-1:0] panel_num;
    logic             start_prev_r;
    logic             start_edge;
    logic             sel_ok;

    assign lock_act  = ~pins_s[0];
    assign start_act = ~pins_s[1];
    assign stop_act  = ~pins_s[2];
    assign sel_code  = pins_s[7:3];
    assign panel_num = ~sel_code;

    function automatic logic panel_in_range(input logic [SEL_W-1:0] num);
        panel_in_range = (num >= PANEL_MIN) && (num <= PANEL_MAX);
    endfunction

    assign sel_ok     = panel_in_range(panel_num);
    assign start_edge = start_act && !start_prev_r;

    always_ff @(posedge clock)
    begin
        if (reset)
            start_prev_r <= 1'b0;
        else
            start_prev_r <= start_act;
    end

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign pready  = 1'b1;
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_RESULT) ||
                     (paddr == OFS_IRQ_ST) || (paddr == OFS_IRQ_MSK) || (paddr == OFS_ITEM);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pwrite;

    logic ctrl_wr;
    logic item_req;
    logic done_req;
    logic remote_r;

    assign ctrl_wr  = wr_en && (paddr == OFS_CTRL);
    assign item_req = ctrl_wr && pwdata[CTRL_ITEM];
    assign done_req = ctrl_wr && pwdata[CTRL_DONE];

    always_ff @(posedge clock)
    begin
        if (reset)
            remote_r <= 1'b0;
        else if (ctrl_wr)
            remote_r <= pwdata[CTRL_REMOTE];
    end

    assign remote_icon = remote_r;
    assign keys_locked = lock_act || remote_r;

    // ------------------------------------------------------------
    // Measurement sequencer
    // ------------------------------------------------------------
    rtcp_state_t state_r;
    rtcp_state_t state_nxt;
    logic [15:0] strobe_cnt_r;
    logic [15:0] item_cnt_r;
    logic        accept;

    assign accept = (state_r == RTCP_IDLE) && start_edge && sel_ok && !stop_act;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            RTCP_IDLE:
                if (accept)
                    state_nxt = RTCP_MEASURE;
            RTCP_MEASURE:
                if (stop_act || done_req)
                    state_nxt = RTCP_IDLE;
                else if (item_req)
                    state_nxt = RTCP_STROBE;
            RTCP_STROBE:
                if (stop_act)
                    state_nxt = RTCP_IDLE;
                else if (strobe_cnt_r == 16'(STROBE_CYCLES - 1))
                    state_nxt = RTCP_MEASURE;
            default:
                state_nxt = RTCP_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_r <= RTCP_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clock)
    begin
        if (reset || state_r != RTCP_STROBE)
            strobe_cnt_r <= 16'h0000;
        else
            strobe_cnt_r <= strobe_cnt_r + 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (reset || accept)
            item_cnt_r <= 16'h0000;
        else if (state_r == RTCP_MEASURE && state_nxt == RTCP_STROBE)
            item_cnt_r <= item_cnt_r + 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            recall_valid <= 1'b0;
            recall_panel <= 5'h00;
        end
        else
        begin
            recall_valid <= accept;
            if (accept)
                recall_panel <= panel_num;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            abort <= 1'b0;
        else
            abort <= (state_r != RTCP_IDLE) && stop_act;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            testing_n <= 1'b1;
        else
            testing_n <= !(state_nxt != RTCP_IDLE);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            item_strobe_n <= 1'b1;
        else
            item_strobe_n <= !(state_nxt == RTCP_STROBE);
    end

    // ------------------------------------------------------------
    // Judgement
    // ------------------------------------------------------------
    rtcp_judge_t judge_r;

    always_ff @(posedge clock)
    begin
        if (reset || accept)
            judge_r <= RTCP_JUDGE_NONE;
        else if (state_r == RTCP_MEASURE && done_req && !stop_act)
        begin
            if (pwdata[CTRL_HFAIL])
                judge_r <= RTCP_JUDGE_HFAIL;
            else if (pwdata[CTRL_LFAIL])
                judge_r <= RTCP_JUDGE_LFAIL;
            else if (pwdata[CTRL_PASS])
                judge_r <= RTCP_JUDGE_PASS;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset || accept)
        begin
            pass_n  <= 1'b1;
            lfail_n <= 1'b1;
            hfail_n <= 1'b1;
        end
        else
        begin
            pass_n  <= !(judge_r == RTCP_JUDGE_PASS);
            lfail_n <= !(judge_r == RTCP_JUDGE_LFAIL);
            hfail_n <= !(judge_r == RTCP_JUDGE_HFAIL);
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_msk_r;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign irq_set[IRQ_START]  = accept;
    assign irq_set[IRQ_STOP]   = (state_r != RTCP_IDLE) && stop_act;
    assign irq_set[IRQ_DONE]   = (state_r == RTCP_MEASURE) && done_req && !stop_act;
    assign irq_set[IRQ_BADSEL] = (state_r == RTCP_IDLE) && start_edge && !sel_ok;
    assign irq_clr = (wr_en && paddr == OFS_IRQ_ST) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clock)
    begin
        if (reset)
            irq_st_r <= '0;
        else
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            irq_msk_r <= '0;
        else if (wr_en && paddr == OFS_IRQ_MSK)
            irq_msk_r <= pwdata[IRQ_W-1:0];
    end

    assign irq = |(irq_st_r & irq_msk_r);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (reset)
            prdata <= RST_WORD;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                OFS_CTRL:    prdata <= {31'h0000_0000, remote_r};
                OFS_STATUS:  prdata <= {20'h0_0000, sel_code, state_r, keys_locked,
                                        stop_act, start_act, lock_act, sel_ok};
                OFS_RESULT:  prdata <= {25'h000_0000, recall_panel, judge_r};
                OFS_IRQ_ST:  prdata <= {28'h000_0000, irq_st_r};
                OFS_IRQ_MSK: prdata <= {28'h000_0000, irq_msk_r};
                OFS_ITEM:    prdata <= {16'h0000, item_cnt_r};
                default:     prdata <= RST_WORD;
            endcase
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;

endmodule

// *** rtcp_pkg.sv ***
// Constants and types shared by the remote test control port.
package rtcp_pkg;

    // ------------------------------------------------------------
    // Panel selection
    // ------------------------------------------------------------
    localparam int          SEL_W       = 5;
    localparam logic [4:0]  PANEL_MIN   = 5'h01;
    localparam logic [4:0]  PANEL_MAX   = 5'h1E;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_RESULT  = 12'h008;
    localparam logic [11:0] OFS_IRQ_ST  = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h010;
    localparam logic [11:0] OFS_ITEM    = 12'h014;

    // Control register fields, all write-one pulses except REMOTE.
    localparam int          CTRL_REMOTE = 0;
    localparam int          CTRL_ITEM   = 1;
    localparam int          CTRL_PASS   = 2;
    localparam int          CTRL_LFAIL  = 3;
    localparam int          CTRL_HFAIL  = 4;
    localparam int          CTRL_DONE   = 5;

    // Interrupt status fields.
    localparam int          IRQ_START   = 0;
    localparam int          IRQ_STOP    = 1;
    localparam int          IRQ_DONE    = 2;
    localparam int          IRQ_BADSEL  = 3;
    localparam int          IRQ_W       = 4;

    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          STROBE_NS   = 1000;
    localparam int          STROBE_CYC  = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        RTCP_IDLE    = 2'b00,
        RTCP_MEASURE = 2'b01,
        RTCP_STROBE  = 2'b10
    } rtcp_state_t;

    typedef enum logic [1:0]
    {
        RTCP_JUDGE_NONE  = 2'b00,
        RTCP_JUDGE_PASS  = 2'b01,
        RTCP_JUDGE_LFAIL = 2'b10,
        RTCP_JUDGE_HFAIL = 2'b11
    } rtcp_judge_t;

endpackage

// *** rtcp_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module rtcp_sync
#(
    parameter int          W     = 1,
    parameter logic [W-1:0] INIT = '1
)
(
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            meta_r   <= INIT;
            sync_out <= INIT;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// *** rtcp_checker.sv ***
// Assertion checker bound to the remote test control port.
`timescale 1ns/1ps
module rtcp_checker
#(
    parameter int STROBE_CYCLES = 2
)
(
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       panel_lock_n,
    input wire logic       start_n,
    input wire logic       stop_n,
    input wire logic       panel_sel_b0_n,
    input wire logic       panel_sel_b1_n,
    input wire logic       panel_sel_b2_n,
    input wire logic       panel_sel_b3_n,
    input wire logic       panel_sel_b4_n,
    input wire logic       testing_n,
    input wire logic       item_strobe_n,
    input wire logic       pass_n,
    input wire logic       lfail_n,
    input wire logic       hfail_n,
    input wire logic       keys_locked,
    input wire logic       remote_icon,
    input wire logic       recall_valid,
    input wire logic [4:0] recall_panel
);
    // ------------------------------------------------------------
    // Pin relations
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    int cnt_r;
    always_ff @(posedge clock)
        cnt_r <= (reset || item_strobe_n) ? 0 : cnt_r + 1;
    property p_lock; !panel_lock_n [*4] |-> keys_locked; endproperty
    a_lock: assert property (p_lock) else $error("keys not locked");
    property p_free; panel_lock_n [*4] ##0 !remote_icon |-> !keys_locked; endproperty
    a_free: assert property (p_free) else $error("keys still locked");
    property p_remote; remote_icon |-> keys_locked; endproperty
    a_remote: assert property (p_remote) else $error("remote without lock");
    property p_start; recall_valid |-> !$past(start_n, 3) && $past(start_n, 4); endproperty
    a_start: assert property (p_start) else $error("accept without start");
    property p_recall; recall_valid |-> recall_panel == ~{panel_sel_b4_n,
        panel_sel_b3_n, panel_sel_b2_n, panel_sel_b1_n, panel_sel_b0_n}; endproperty
    a_recall: assert property (p_recall) else $error("wrong panel");
    property p_test; recall_valid |-> !testing_n && $past(testing_n); endproperty
    a_test: assert property (p_test) else $error("testing not entered");
    property p_stop; !stop_n [*6] |-> testing_n; endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_strobe; $rose(item_strobe_n) |-> cnt_r == STROBE_CYCLES; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe width");
    property p_one; $onehot0({!pass_n, !lfail_n, !hfail_n}); endproperty
    a_one: assert property (p_one) else $error("two judgements");
    property p_clear; !testing_n |-> pass_n && lfail_n && hfail_n; endproperty
    a_clear: assert property (p_clear) else $error("judgement not cleared");
endmodule
bind rtcp_port rtcp_checker #(.STROBE_CYCLES(STROBE_CYCLES)) rtcp_checker_i (.*);

// *** rtcp_plc.sv ***
// External controller model that drives the port's input pins.
`timescale 1ns/1ps
module rtcp_plc
(
    input wire logic clock,
    output logic     panel_lock_n,
    output logic     start_n,
    output logic     stop_n,
    output logic     panel_sel_b0_n,
    output logic     panel_sel_b1_n,
    output logic     panel_sel_b2_n,
    output logic     panel_sel_b3_n,
    output logic     panel_sel_b4_n
);
    // ------------------------------------------------------------
    // Pin drive, all lines idle high
    // ------------------------------------------------------------
    initial
    begin
        {panel_lock_n, start_n, stop_n} <= 3'h7;
        {panel_sel_b4_n, panel_sel_b3_n, panel_sel_b2_n} <= 3'h7;
        {panel_sel_b1_n, panel_sel_b0_n} <= 2'h3;
    end
    task automatic run(input logic [4:0] code, input int hold);
        @(posedge clock);
        {panel_sel_b4_n, panel_sel_b3_n, panel_sel_b2_n,
         panel_sel_b1_n, panel_sel_b0_n} <= code;
        repeat (4) @(posedge clock);
        start_n <= 1'b0;
        repeat (hold) @(posedge clock);
        start_n <= 1'b1;
    endtask
    task automatic halt(input int hold);
        @(posedge clock);
        stop_n <= 1'b0;
        repeat (hold) @(posedge clock);
        stop_n <= 1'b1;
    endtask
    task automatic lock(input logic v);
        @(posedge clock);
        panel_lock_n <= v;
    endtask
endmodule

// *** rtcp_port_tb.sv ***
// Self-checking testbench for the remote test control port.
`timescale 1ns/1ps
module rtcp_port_tb;
    import rtcp_pkg::*;
    localparam int SC = 4;
    logic        clock, reset, panel_lock_n, start_n, stop_n, testing_n;
    logic        panel_sel_b0_n, panel_sel_b1_n, panel_sel_b2_n;
    logic        panel_sel_b3_n, panel_sel_b4_n, item_strobe_n, pass_n;
    logic        lfail_n, hfail_n, keys_locked, remote_icon, recall_valid;
    logic        abort, irq, psel, penable, pwrite, pready, pslverr, er;
    logic [4:0]  recall_panel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt, check_count, abort_cyc;
    always_ff @(posedge clock)
        abort_cyc <= abort_cyc + int'(abort);
    rtcp_port #(.STROBE_CYCLES(SC)) rtcp_port_i (.*);
    rtcp_plc rtcp_plc_i (.*);
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_lock;
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0000, rd);
        rtcp_plc_i.lock(1'b0);
        cyc(4);
        chk("keys_locked", 1, keys_locked);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0F92, rd);
        rtcp_plc_i.lock(1'b1);
        cyc(4);
        chk("keys_locked", 0, keys_locked);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        chk("keys_locked", 1, keys_locked);
        chk("remote_icon", 1, remote_icon);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("pslverr", 1, er);
        chk("unmapped read", 32'h0000_0000, rd);
    endtask
    task automatic s_run(input logic [4:0] p, input logic [31:0] c, input logic [2:0] j,
                         input logic [1:0] jc);
        int n;
        rtcp_plc_i.run(~p, 2);
        for (int i = 0; i < 30 && testing_n !== 1'b0; i++)
            cyc(1);
        chk("testing_n", 0, testing_n);
        chk("recall_panel", p, recall_panel);
        chk("judge", 3'h7, {pass_n, lfail_n, hfail_n});
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        n = 0;
        for (int i = 0; i < 20; i++)
        begin
            n += !item_strobe_n;
            cyc(1);
        end
        chk("strobe cycles", SC, n);
        apb(1'b0, OFS_ITEM, 32'h0000_0000);
        chk("item count", 32'h0000_0001, rd);
        apb(1'b1, OFS_CTRL, c);
        cyc(2);
        chk("testing_n", 1, testing_n);
        chk("judge", j, {pass_n, lfail_n, hfail_n});
        apb(1'b0, OFS_RESULT, 32'h0000_0000);
        chk("result", {25'h000_0000, p, jc}, rd);
    endtask
    task automatic s_bad;
        apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
        rtcp_plc_i.run(5'h1F, 2);
        cyc(6);
        chk("testing_n", 1, testing_n);
        chk("irq masked", 0, irq);
        apb(1'b1, OFS_IRQ_MSK, 32'h0000_0008);
        chk("irq", 1, irq);
        rtcp_plc_i.run(5'h00, 2);
        cyc(6);
        chk("testing_n", 1, testing_n);
        apb(1'b0, OFS_IRQ_ST, 32'h0000_0000);
        chk("irq status", 32'h0000_0008, rd);
        apb(1'b1, OFS_IRQ_ST, 32'h0000_0008);
        cyc(1);
        chk("irq cleared", 0, irq);
    endtask
    task automatic s_stop;
        rtcp_plc_i.run(~5'h09, 8);
        chk("testing_n", 0, testing_n);
        rtcp_plc_i.halt(8);
        cyc(1);
        chk("testing_n", 1, testing_n);
        chk("judge", 3'h7, {pass_n, lfail_n, hfail_n});
        chk("abort cycles", 1, abort_cyc);
        apb(1'b0, OFS_IRQ_ST, 32'h0000_0000);
        chk("irq status", 32'h0000_0003, rd);
    endtask
    // ------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 3'h0, 12'h000, 32'h0000_0000};
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        cyc(2);
        s_lock;
        s_run(5'h01, 32'h0000_0024, 3'h3, 2'h1);
        s_run(5'h1E, 32'h0000_0028, 3'h5, 2'h2);
        s_run(5'h11, 32'h0000_0030, 3'h6, 2'h3);
        s_run(5'h05, 32'h0000_0034, 3'h6, 2'h3);
        s_bad;
        s_stop;
        close_out;
    end
    initial
    begin
        #200_000;
        error_cnt++;
        close_out;
    end
endmodule
